/* File: shared/smcd_map.vh */
`ifndef SMCD_MAP_VH
`define SMCD_MAP_VH

// ----------------------------------------------------------------------------
// Descriptor layout
// ----------------------------------------------------------------------------
`define SMCD_DESC_W 16
`define SMCD_DESC_RST 16'h0000
`define SMCD_FLAG_EMPTY 15
`define SMCD_FLAG_READY 15
`define SMCD_FLAG_LAST 14
`define SMCD_FLAG_ERR 13
`define SMCD_FLAG_ABORT 13
`define SMCD_FLAG_MISM 12
`define SMCD_FLAG_ABIT 9
`define SMCD_FLAG_EBIT 8
`define SMCD_DATA_HI 7
`define SMCD_DATA_LO 0
`define SMCD_CI_HI 5
`define SMCD_CI_LO 2
`define SMCD_CI_PAD_HI 1
`define SMCD_RSV_HI 14
`define SMCD_RSV_LO 6

// ----------------------------------------------------------------------------
// Descriptor index on the host word port
// ----------------------------------------------------------------------------
`define SMCD_IDX_MON_RX 2'h0
`define SMCD_IDX_MON_TX 2'h1
`define SMCD_IDX_CI_RX 2'h2
`define SMCD_IDX_CI_TX 2'h3

// ----------------------------------------------------------------------------
// Channel mode field bits
// ----------------------------------------------------------------------------
`define SMCD_MODE_TRANSP 3
`define SMCD_MODE_LINK 2
`define SMCD_MODE_MON 1

// ----------------------------------------------------------------------------
// Serial frame slots, first bit on the wire is bit 0
// ----------------------------------------------------------------------------
`define SMCD_FRAME_BITS 18
`define SMCD_CNT_W 5
`define SMCD_SLOT_MON_HI 7
`define SMCD_SLOT_MON_LO 0
`define SMCD_SLOT_CH2_HI 15
`define SMCD_SLOT_CH2_LO 8
`define SMCD_SLOT_A 16
`define SMCD_SLOT_E 17
`define SMCD_FIFO_DEPTH 8

`endif

/* File: hdl/smcd_fifo.v */
module smcd_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clock)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule

/* File: hdl/smcd_top.v */
`include "smcd_map.vh"

module smcd_top #(
  parameter FIFO_DEPTH = `SMCD_FIFO_DEPTH,
  parameter FIFO_AW = 3
) (
  input wire clock,
  input wire rstn,
  input wire [3:0] channel_mode_field,
  input wire loop_mode,
  input wire channel_one_enable,
  input wire channel_two_enable,
  input wire [1:0] irq_mask,
  input wire host_sel,
  input wire host_we,
  input wire [1:0] host_addr,
  input wire [`SMCD_DESC_W-1:0] host_wdata,
  output reg [`SMCD_DESC_W-1:0] host_rdata,
  input wire layer1_clock,
  input wire layer1_sync,
  input wire layer1_rxd,
  output reg layer1_txd,
  output reg layer1_txd_oe,
  output reg mon_irq,
  output reg ci_irq
);

  localparam [1:0] TX_IDLE = 2'b00;
  localparam [1:0] TX_WAIT = 2'b01;
  localparam [1:0] TX_EOM = 2'b10;
  localparam [`SMCD_CNT_W-1:0] FRAME_N = `SMCD_FRAME_BITS;
  localparam FW = `SMCD_FRAME_BITS;

  // --------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------------------
  reg rst_meta;
  reg rst_n;
  reg [2:0] clk_sync;
  reg [1:0] sync_sync;
  reg [1:0] rxd_sync;

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // The third clock stage only feeds edge detection, never the first stage.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_sync <= 3'h0;
      sync_sync <= 2'h0;
      rxd_sync <= 2'h0;
    end
    else
    begin
      clk_sync <= {clk_sync[1:0], layer1_clock};
      sync_sync <= {sync_sync[0], layer1_sync};
      rxd_sync <= {rxd_sync[0], layer1_rxd};
    end
  end

  wire l1_rise = clk_sync[1] && !clk_sync[2];
  wire l1_fall = !clk_sync[1] && clk_sync[2];

  // --------------------------------------------------------------------------
  // Frame shifter on the link side
  // --------------------------------------------------------------------------
  reg [`SMCD_CNT_W-1:0] bit_cnt;
  reg [FW-1:0] rx_sh;
  reg [FW-1:0] tx_cur;
  reg frame_done;
  wire [FW-1:0] tx_frame;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire host_wr = host_sel && host_we;
  // Host writes take the descriptors, so frame processing waits a cycle.
  wire pop = fifo_out_valid && !host_wr;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt <= 5'h00;
      rx_sh <= 18'h00000;
      tx_cur <= 18'h00000;
      frame_done <= 1'b0;
      layer1_txd <= 1'b0;
      layer1_txd_oe <= 1'b0;
    end
    else
    begin
      frame_done <= 1'b0;
      if (l1_rise && sync_sync[1])
      begin
        bit_cnt <= 5'h01;
        rx_sh <= {rxd_sync[1], rx_sh[FW-1:1]};
        tx_cur <= tx_frame;
        frame_done <= (FRAME_N == 5'h01);
      end
      else if (l1_rise && bit_cnt != 5'h00 && bit_cnt < FRAME_N)
      begin
        bit_cnt <= bit_cnt + 5'h01;
        rx_sh <= {rxd_sync[1], rx_sh[FW-1:1]};
        frame_done <= (bit_cnt + 5'h01 == FRAME_N);
      end
      // Dropping back to idle after the last bit lets the driver release the line.
      else if (l1_rise && bit_cnt == FRAME_N)
        bit_cnt <= 5'h00;
      if (l1_fall)
      begin
        layer1_txd_oe <= (bit_cnt != 5'h00) && (bit_cnt <= FRAME_N);
        layer1_txd <= (bit_cnt != 5'h00) ? tx_cur[bit_cnt - 5'h01] : 1'b0;
      end
    end
  end

  // A frame that finds the buffer full is lost; the drain only stalls on host writes.
  smcd_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(frame_done),
    .in_ready(fifo_in_ready),
    .in_data(loop_mode ? tx_cur : rx_sh),
    .out_valid(fifo_out_valid),
    .out_ready(!host_wr),
    .out_data(fifo_out_data)
  );

  // --------------------------------------------------------------------------
  // Mode decode and received fields
  // --------------------------------------------------------------------------
  wire link_mode = channel_mode_field[`SMCD_MODE_LINK];
  wire mon_proto = !link_mode && channel_mode_field[`SMCD_MODE_MON] && !channel_mode_field[`SMCD_MODE_TRANSP];
  wire mon_transp = !link_mode && channel_mode_field[`SMCD_MODE_MON] && channel_mode_field[`SMCD_MODE_TRANSP];
  wire [7:0] f_mon = fifo_out_data[`SMCD_SLOT_MON_HI:`SMCD_SLOT_MON_LO];
  wire [7:0] f_ch2 = fifo_out_data[`SMCD_SLOT_CH2_HI:`SMCD_SLOT_CH2_LO];
  wire [3:0] f_ci = f_ch2[`SMCD_CI_HI:`SMCD_CI_LO];
  wire f_a = fifo_out_data[`SMCD_SLOT_A];
  wire f_e = fifo_out_data[`SMCD_SLOT_E];

  // --------------------------------------------------------------------------
  // Descriptors and channel state
  // --------------------------------------------------------------------------
  reg [15:0] mon_rx_descriptor;
  reg [15:0] mon_tx_descriptor;
  reg [15:0] ci_rx_descriptor;
  reg [15:0] ci_tx_descriptor;
  reg [7:0] tx_byte;
  reg tx_a;
  reg tx_e;
  reg [7:0] ch2_byte;
  reg [7:0] mon_prev;
  reg mon_prev_ok;
  reg mon_stored;
  reg ack_pend;
  reg msg_active;
  reg [1:0] tx_state;
  reg [3:0] ci_prev;
  reg [3:0] ci_held;
  reg [15:0] next_mrx;
  reg [15:0] next_mtx;
  reg [15:0] next_crx;
  reg [15:0] next_ctx;
  reg [7:0] next_tx_byte;
  reg next_tx_a;
  reg next_tx_e;
  reg [7:0] next_ch2_byte;
  reg [7:0] next_prev;
  reg next_prev_ok;
  reg next_stored;
  reg next_ack_pend;
  reg next_msg;
  reg [1:0] next_tx_state;
  reg [3:0] next_ci_prev;
  reg [3:0] next_ci_held;
  reg ev_mon;
  reg ev_ci;

  assign tx_frame = {tx_e, tx_a, ch2_byte, tx_byte};

  always @*
  begin
    next_mrx = mon_rx_descriptor;
    next_mtx = mon_tx_descriptor;
    next_crx = ci_rx_descriptor;
    next_ctx = ci_tx_descriptor;
    next_tx_byte = tx_byte;
    next_tx_a = tx_a;
    next_tx_e = tx_e;
    next_ch2_byte = ch2_byte;
    next_prev = mon_prev;
    next_prev_ok = mon_prev_ok;
    next_stored = mon_stored;
    next_ack_pend = ack_pend;
    next_msg = msg_active;
    next_tx_state = tx_state;
    next_ci_prev = ci_prev;
    next_ci_held = ci_held;
    ev_mon = 1'b0;
    ev_ci = 1'b0;
    if (pop && channel_one_enable && mon_proto)
    begin
      // The acknowledge is a one-frame pulse on A, sent only once the host has emptied the buffer.
      next_tx_a = ack_pend && mon_rx_descriptor[`SMCD_FLAG_EMPTY];
      if (next_tx_a)
        next_ack_pend = 1'b0;
      if (f_e)
      begin
        next_msg = 1'b1;
        next_prev = f_mon;
        next_prev_ok = 1'b1;
        if (mon_prev_ok && f_mon != mon_prev)
        begin
          next_mrx[`SMCD_FLAG_MISM] = 1'b1;
          next_stored = 1'b0;
          if (next_ack_pend)
          begin
            next_mrx[`SMCD_FLAG_LAST] = 1'b1;
            next_mrx[`SMCD_FLAG_ERR] = 1'b1;
            next_mrx[`SMCD_FLAG_EMPTY] = 1'b0;
            next_ack_pend = 1'b0;
            ev_mon = 1'b1;
          end
        end
        else if (mon_prev_ok)
        begin
          next_mrx[`SMCD_FLAG_MISM] = 1'b0;
          if (!mon_stored && !ack_pend && mon_rx_descriptor[`SMCD_FLAG_EMPTY])
          begin
            next_mrx[`SMCD_DATA_HI:`SMCD_DATA_LO] = f_mon;
            next_mrx[`SMCD_FLAG_EMPTY] = 1'b0;
            next_mrx[`SMCD_FLAG_LAST] = 1'b0;
            next_mrx[`SMCD_FLAG_ERR] = 1'b0;
            next_stored = 1'b1;
            next_ack_pend = 1'b1;
            ev_mon = 1'b1;
          end
        end
      end
      else if (msg_active)
      begin
        next_msg = 1'b0;
        next_prev_ok = 1'b0;
        next_stored = 1'b0;
        next_ack_pend = 1'b0;
        next_mrx[`SMCD_FLAG_LAST] = 1'b1;
        next_mrx[`SMCD_FLAG_EMPTY] = 1'b0;
        ev_mon = 1'b1;
      end
      case (tx_state)
        TX_IDLE:
        begin
          if (mon_tx_descriptor[`SMCD_FLAG_READY])
          begin
            next_tx_byte = mon_tx_descriptor[`SMCD_DATA_HI:`SMCD_DATA_LO];
            next_tx_e = 1'b1;
            next_tx_state = TX_WAIT;
          end
          else if (f_a && tx_e)
          begin
            next_mtx[`SMCD_FLAG_ABORT] = 1'b1;
            next_tx_e = 1'b0;
            ev_mon = 1'b1;
          end
        end
        TX_WAIT:
        begin
          if (f_a)
          begin
            next_mtx[`SMCD_FLAG_READY] = 1'b0;
            ev_mon = 1'b1;
            next_tx_state = mon_tx_descriptor[`SMCD_FLAG_LAST] ? TX_EOM : TX_IDLE;
          end
        end
        TX_EOM:
        begin
          next_tx_e = 1'b0;
          next_tx_state = TX_IDLE;
        end
        default:
          next_tx_state = TX_IDLE;
      endcase
    end
    else if (pop && channel_one_enable && (mon_transp || link_mode))
    begin
      if (mon_rx_descriptor[`SMCD_FLAG_EMPTY])
      begin
        next_mrx[`SMCD_DATA_HI:`SMCD_DATA_LO] = f_mon;
        next_mrx[`SMCD_FLAG_ABIT] = f_a;
        next_mrx[`SMCD_FLAG_EBIT] = f_e;
        next_mrx[`SMCD_FLAG_EMPTY] = 1'b0;
        ev_mon = 1'b1;
      end
      if (mon_tx_descriptor[`SMCD_FLAG_READY])
      begin
        next_tx_byte = mon_tx_descriptor[`SMCD_DATA_HI:`SMCD_DATA_LO];
        next_tx_a = mon_tx_descriptor[`SMCD_FLAG_ABIT];
        next_tx_e = mon_tx_descriptor[`SMCD_FLAG_EBIT];
        next_mtx[`SMCD_FLAG_READY] = 1'b0;
        ev_mon = 1'b1;
      end
    end
    if (pop && channel_two_enable)
    begin
      if (link_mode)
      begin
        if (ci_rx_descriptor[`SMCD_FLAG_EMPTY])
        begin
          next_crx[`SMCD_DATA_HI:`SMCD_DATA_LO] = f_ch2;
          next_crx[`SMCD_FLAG_ABIT] = f_a;
          next_crx[`SMCD_FLAG_EBIT] = f_e;
          next_crx[`SMCD_FLAG_EMPTY] = 1'b0;
          ev_ci = 1'b1;
        end
      end
      else
      begin
        // A new value counts only when seen in two successive frames.
        next_ci_prev = f_ci;
        if (f_ci == ci_prev && f_ci != ci_held && ci_rx_descriptor[`SMCD_FLAG_EMPTY])
        begin
          next_crx = `SMCD_DESC_RST;
          next_crx[`SMCD_CI_HI:`SMCD_CI_LO] = f_ci;
          next_crx[`SMCD_CI_PAD_HI:0] = 2'h0;
          next_ci_held = f_ci;
          ev_ci = 1'b1;
        end
      end
      if (ci_tx_descriptor[`SMCD_FLAG_READY])
      begin
        next_ch2_byte = ci_tx_descriptor[`SMCD_DATA_HI:`SMCD_DATA_LO];
        next_ctx[`SMCD_FLAG_READY] = 1'b0;
        ev_ci = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Descriptor storage and host word port
  // --------------------------------------------------------------------------
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mon_rx_descriptor <= `SMCD_DESC_RST;
      mon_tx_descriptor <= `SMCD_DESC_RST;
      ci_rx_descriptor <= `SMCD_DESC_RST;
      ci_tx_descriptor <= `SMCD_DESC_RST;
      host_rdata <= `SMCD_DESC_RST;
      tx_byte <= 8'h00;
      tx_a <= 1'b0;
      tx_e <= 1'b0;
      ch2_byte <= 8'h00;
      mon_prev <= 8'h00;
      mon_prev_ok <= 1'b0;
      mon_stored <= 1'b0;
      ack_pend <= 1'b0;
      msg_active <= 1'b0;
      tx_state <= TX_IDLE;
      ci_prev <= 4'h0;
      ci_held <= 4'h0;
      mon_irq <= 1'b0;
      ci_irq <= 1'b0;
    end
    else
    begin
      if (host_wr)
      begin
        case (host_addr)
          `SMCD_IDX_MON_RX: mon_rx_descriptor <= host_wdata;
          `SMCD_IDX_MON_TX: mon_tx_descriptor <= host_wdata;
          `SMCD_IDX_CI_RX: ci_rx_descriptor <= host_wdata;
          default: ci_tx_descriptor <= host_wdata;
        endcase
      end
      else if (pop)
      begin
        mon_rx_descriptor <= next_mrx;
        mon_tx_descriptor <= next_mtx;
        ci_rx_descriptor <= next_crx;
        ci_tx_descriptor <= next_ctx;
      end
      if (host_sel && !host_we)
      begin
        case (host_addr)
          `SMCD_IDX_MON_RX: host_rdata <= mon_rx_descriptor;
          `SMCD_IDX_MON_TX: host_rdata <= mon_tx_descriptor;
          `SMCD_IDX_CI_RX: host_rdata <= ci_rx_descriptor;
          default: host_rdata <= ci_tx_descriptor;
        endcase
      end
      if (pop)
      begin
        tx_byte <= next_tx_byte;
        tx_a <= next_tx_a;
        tx_e <= next_tx_e;
        ch2_byte <= next_ch2_byte;
        mon_prev <= next_prev;
        mon_prev_ok <= next_prev_ok;
        mon_stored <= next_stored;
        ack_pend <= next_ack_pend;
        msg_active <= next_msg;
        tx_state <= next_tx_state;
        ci_prev <= next_ci_prev;
        ci_held <= next_ci_held;
      end
      mon_irq <= ev_mon && channel_one_enable && !irq_mask[0];
      ci_irq <= ev_ci && channel_two_enable && !irq_mask[1];
    end
  end

endmodule

/* File: dv/smcd_top_chk.sv */
module smcd_top_chk (
  input wire clock,
  input wire rstn,
  input wire channel_one_enable,
  input wire channel_two_enable,
  input wire [1:0] irq_mask,
  input wire host_sel,
  input wire host_we,
  input wire [1:0] host_addr,
  input wire [15:0] host_wdata,
  input wire [15:0] host_rdata,
  input wire mon_irq,
  input wire ci_irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // ---------------------------------------------------------------------------
  // Interrupt requests
  // ---------------------------------------------------------------------------
  chk_mon_pulse: assert property (mon_irq |=> !mon_irq)
    else $error("mon_irq held longer than one cycle");
  chk_ci_pulse: assert property (ci_irq |=> !ci_irq)
    else $error("ci_irq held longer than one cycle");
  chk_mon_masked: assert property (irq_mask[0] && $past(irq_mask[0]) |-> !mon_irq)
    else $error("mon_irq raised while masked");
  chk_ci_masked: assert property (irq_mask[1] && $past(irq_mask[1]) |-> !ci_irq)
    else $error("ci_irq raised while masked");
  chk_mon_disabled: assert property (!$past(channel_one_enable) && !$past(channel_one_enable, 2) |-> !mon_irq)
    else $error("mon_irq raised while channel disabled");
  chk_ci_disabled: assert property (!$past(channel_two_enable) && !$past(channel_two_enable, 2) |-> !ci_irq)
    else $error("ci_irq raised while channel disabled");

  // ---------------------------------------------------------------------------
  // Host word port
  // ---------------------------------------------------------------------------
  chk_rdata_hold: assert property (!($past(host_sel) && !$past(host_we)) |-> $stable(host_rdata))
    else $error("read data changed without a read");
  chk_write_read: assert property (host_sel && host_we ##1 host_sel && !host_we && $stable(host_addr)
    |=> host_rdata == $past(host_wdata, 2))
    else $error("read back differs from written word");
endmodule

bind smcd_top smcd_top_chk u_chk (.clock(clock), .rstn(rstn), .channel_one_enable(channel_one_enable),
  .channel_two_enable(channel_two_enable), .irq_mask(irq_mask), .host_sel(host_sel), .host_we(host_we),
  .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .mon_irq(mon_irq), .ci_irq(ci_irq));

/* File: dv/smcd_l1_model.sv */
module smcd_l1_model (
  output logic layer1_clock,
  output logic layer1_sync,
  output logic layer1_rxd,
  input wire logic layer1_txd,
  input wire logic layer1_txd_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    layer1_clock = 1'h0;
    layer1_sync = 1'h0;
    layer1_rxd = 1'h1;
  end

  // One frame of 18 bits; the clock stands still between frames and the data
  // line shows the inverse of its last bit, so a stale sample cannot pass.
  task automatic frame(input logic [17:0] rx, output logic [17:0] tx, output logic [17:0] oe);
    for (int i = 0; i < 19; i++)
    begin
      layer1_sync = (i == 0);
      layer1_rxd = (i < 18) ? rx[i] : ~rx[17];
      #200 layer1_clock = 1'h1;
      #200 layer1_clock = 1'h0;
      if (i > 0)
      begin
        tx[i-1] = layer1_txd;
        oe[i-1] = layer1_txd_oe;
      end
    end
    #2000;
  endtask
endmodule

/* File: dv/smcd_top_tb_top.sv */
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module smcd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rstn, loop_mode, channel_one_enable, channel_two_enable, host_sel, host_we;
  logic [3:0] channel_mode_field;
  logic [1:0] irq_mask, host_addr;
  logic [15:0] host_wdata, d;
  logic [17:0] tx, oe;
  wire [15:0] host_rdata;
  wire layer1_clock, layer1_sync, layer1_rxd, layer1_txd, layer1_txd_oe, mon_irq, ci_irq;
  int fails = 0;
  int comparisons = 0;
  int mon_cnt = 0;
  int ci_cnt = 0;
  int c;

  smcd_top u_dut (.clock(clock), .rstn(rstn), .channel_mode_field(channel_mode_field), .loop_mode(loop_mode),
    .channel_one_enable(channel_one_enable), .channel_two_enable(channel_two_enable), .irq_mask(irq_mask),
    .host_sel(host_sel), .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .layer1_clock(layer1_clock), .layer1_sync(layer1_sync), .layer1_rxd(layer1_rxd),
    .layer1_txd(layer1_txd), .layer1_txd_oe(layer1_txd_oe), .mon_irq(mon_irq), .ci_irq(ci_irq));

  smcd_l1_model u_l1 (.layer1_clock(layer1_clock), .layer1_sync(layer1_sync), .layer1_rxd(layer1_rxd),
    .layer1_txd(layer1_txd), .layer1_txd_oe(layer1_txd_oe));

  initial
  begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (mon_irq === 1'h1)
      mon_cnt++;
    if (ci_irq === 1'h1)
      ci_cnt++;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task summarize;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A write is always followed at once by a read of the same word, so the
  // checker sees every write read back.
  task wr(input logic [1:0] a, input logic [15:0] v);
    @(negedge clock);
    host_sel = 1'h1;
    host_we = 1'h1;
    host_addr = a;
    host_wdata = v;
    @(negedge clock);
    host_we = 1'h0;
    @(negedge clock);
    host_sel = 1'h0;
  endtask

  task rd(input logic [1:0] a, output logic [15:0] v);
    @(negedge clock);
    host_sel = 1'h1;
    host_we = 1'h0;
    host_addr = a;
    @(negedge clock);
    host_sel = 1'h0;
    @(negedge clock);
    v = host_rdata;
  endtask

  task fr(input logic [7:0] m, input logic [7:0] s, input logic a, input logic e);
    u_l1.frame({e, a, s, m}, tx, oe);
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    #1000000;
    fails++;
    summarize();
  end

  initial
  begin
    rstn = 1'h0;
    loop_mode = 1'h0;
    channel_mode_field = 4'h2;
    channel_one_enable = 1'h0;
    channel_two_enable = 1'h1;
    irq_mask = 2'h0;
    host_sel = 1'h0;
    host_we = 1'h0;
    host_addr = 2'h0;
    host_wdata = 16'h0000;
    repeat (8) @(negedge clock);
    rstn = 1'h1;
    repeat (5) @(negedge clock);
    for (int i = 0; i < 4; i++)
    begin
      rd(i[1:0], d);
      `CHK(d, 16'h0000)
    end
    wr(2'h2, 16'h8000);
    c = ci_cnt;
    fr(8'h00, 8'h2B, 1'h0, 1'h0);
    fr(8'h00, 8'h2B, 1'h0, 1'h0);
    rd(2'h2, d);
    `CHK(d, 16'h0028)
    `CHK(ci_cnt, c + 1)
    `CHK(oe, 18'h3FFFF)
    `CHK(layer1_txd_oe, 1'h0)
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    rd(2'h2, d);
    `CHK(d, 16'h0028)
    irq_mask = 2'h3;
    wr(2'h2, 16'h8000);
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    rd(2'h2, d);
    `CHK(d, 16'h0014)
    `CHK(ci_cnt, c + 1)
    irq_mask = 2'h0;
    wr(2'h3, 16'h8028);
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    rd(2'h3, d);
    `CHK(d, 16'h0028)
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    `CHK(tx[15:8], 8'h28)
    channel_one_enable = 1'h1;
    channel_two_enable = 1'h0;
    wr(2'h0, 16'h8000);
    fr(8'h12, 8'h14, 1'h0, 1'h1);
    fr(8'h34, 8'h14, 1'h0, 1'h1);
    rd(2'h0, d);
    `CHK(d, 16'h9000)
    c = mon_cnt;
    fr(8'h34, 8'h14, 1'h0, 1'h1);
    rd(2'h0, d);
    `CHK(d, 16'h0034)
    `CHK(mon_cnt, c + 1)
    fr(8'h34, 8'h14, 1'h0, 1'h1);
    `CHK(tx[16], 1'h0)
    wr(2'h0, 16'h8000);
    fr(8'h34, 8'h14, 1'h0, 1'h1);
    fr(8'h34, 8'h14, 1'h0, 1'h0);
    `CHK(tx[16], 1'h1)
    rd(2'h0, d);
    `CHK(d & 16'hC000, 16'h4000)
    wr(2'h0, 16'h8000);
    fr(8'h66, 8'h14, 1'h0, 1'h1);
    fr(8'h66, 8'h14, 1'h0, 1'h1);
    fr(8'h77, 8'h14, 1'h0, 1'h1);
    rd(2'h0, d);
    `CHK(d, 16'h7066)
    wr(2'h1, 16'hC0A5);
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    rd(2'h1, d);
    `CHK(d[15], 1'h1)
    c = mon_cnt;
    fr(8'h00, 8'h14, 1'h1, 1'h0);
    `CHK(tx[7:0], 8'hA5)
    `CHK(tx[17], 1'h1)
    rd(2'h1, d);
    `CHK(d[15], 1'h0)
    `CHK(mon_cnt, c + 1)
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    `CHK(tx[7:0], 8'hA5)
    `CHK(tx[17], 1'h0)
    wr(2'h1, 16'h8011);
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    fr(8'h00, 8'h14, 1'h1, 1'h0);
    fr(8'h00, 8'h14, 1'h1, 1'h0);
    rd(2'h1, d);
    `CHK(d, 16'h2011)
    fr(8'h00, 8'h14, 1'h0, 1'h0);
    `CHK(tx[17], 1'h0)
    channel_mode_field = 4'hA;
    wr(2'h1, 16'h823C);
    wr(2'h0, 16'h8000);
    fr(8'h77, 8'h14, 1'h0, 1'h1);
    rd(2'h0, d);
    `CHK(d, 16'h0177)
    fr(8'h55, 8'h14, 1'h0, 1'h1);
    `CHK(tx[7:0], 8'h3C)
    `CHK({tx[17], tx[16]}, 2'h1)
    rd(2'h0, d);
    `CHK(d, 16'h0177)
    channel_mode_field = 4'h4;
    channel_two_enable = 1'h1;
    wr(2'h2, 16'h8000);
    fr(8'h00, 8'h5A, 1'h1, 1'h0);
    rd(2'h2, d);
    `CHK(d, 16'h025A)
    loop_mode = 1'h1;
    wr(2'h2, 16'h8000);
    fr(8'h00, 8'h00, 1'h0, 1'h0);
    rd(2'h2, d);
    `CHK(d, 16'h0228)
    summarize();
  end
endmodule
